// *** hdl/pcs_error_counter_config.sv ***
`timescale 1ns/1ps
module pcs_error_counter_config (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap, from a pin
    input wire logic fiber_strap,
    // receive status pins
    input wire logic rx_carrier,
    input wire logic rx_symbol_error,
    input wire logic rx_collision,
    // medium status pins
    input wire logic signal_level_valid,
    input wire logic descrambler_locked,
    input wire logic descrambler_activity,
    // datapath controls
    output pcs_pkg::pcs_config_s config_out,
    output logic link_good,
    output logic descrambler_timeout
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [6:0] sync_a;
    logic [6:0] sync_b;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
        end else begin
            sync_a <= {fiber_strap, rx_carrier, rx_symbol_error, rx_collision,
                       signal_level_valid, descrambler_locked, descrambler_activity};
            sync_b <= sync_a;
        end
    end

    logic strap_s;
    logic level_s;
    logic lock_s;
    logic activity_s;
    pcs_pkg::pcs_rx_status_s rx_s;

    assign strap_s = sync_b[6];
    assign rx_s.carrier = sync_b[5];
    assign rx_s.symbol_error = sync_b[4];
    assign rx_s.collision = sync_b[3];
    assign level_s = sync_b[2];
    assign lock_s = sync_b[1];
    assign activity_s = sync_b[0];

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    logic access;
    logic wr_pcr;
    logic rd_rec;
    logic hit;

    assign access = psel && penable;
    assign pready = 1'b1;
    assign hit = (paddr == pcs_pkg::rec_addr) || (paddr == pcs_pkg::pcr_addr)
                 || (paddr == pcs_pkg::extra_addr);
    assign pslverr = access && !hit;
    assign wr_pcr = access && pwrite && (paddr == pcs_pkg::pcr_addr);
    assign rd_rec = access && !pwrite && (paddr == pcs_pkg::rec_addr);

    // ---------------------------------------------------------------
    // receive error count
    // ---------------------------------------------------------------
    logic [7:0] tally;

    pcs_error_tally u_tally (
        .clock(clock),
        .rst_b(rst_b),
        .rx(rx_s),
        .clear(rd_rec),
        .rx_symbol_error_tally(tally)
    );

    // ---------------------------------------------------------------
    // strap capture after reset release
    // ---------------------------------------------------------------
    logic [1:0] strap_wait;
    logic strap_load;

    assign strap_load = (strap_wait == 2'h2);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strap_wait <= 2'h0;
        end else if (strap_wait != 2'h3) begin
            strap_wait <= strap_wait + 2'h1;
        end
    end

    // ---------------------------------------------------------------
    // configuration register
    // ---------------------------------------------------------------
    logic [15:0] pcr;
    logic [15:0] wmask;

    assign wmask = pwdata[15:0] & pcs_pkg::pcr_writable;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pcr <= 16'h0000;
            pcr[pcs_pkg::sd_alg_bit] <= 1'b1;
        end else if (strap_load) begin
            pcr[pcs_pkg::fiber_bit] <= strap_s;
            pcr[pcs_pkg::fefi_bit] <= strap_s;
            pcr[pcs_pkg::scram_bit] <= strap_s;
            pcr[pcs_pkg::descram_bit] <= strap_s;
        end else if (wr_pcr) begin
            pcr <= wmask;
        end
    end

    assign config_out.rx_clk_free_run = pcr[pcs_pkg::free_clk_bit];
    assign config_out.true_quiet_enable = pcr[pcs_pkg::true_quiet_bit];
    assign config_out.force_signal_detect = pcr[pcs_pkg::force_sd_bit];
    assign config_out.signal_detect_algorithm = pcr[pcs_pkg::sd_alg_bit];
    assign config_out.descrambler_timeout_select = pcr[pcs_pkg::descrambler_timeout_select_bit];
    assign config_out.fiber_mode_enable = pcr[pcs_pkg::fiber_bit];
    assign config_out.force_good_link = pcr[pcs_pkg::force_ok_bit];
    assign config_out.far_end_fault_enable = pcr[pcs_pkg::fefi_bit];
    assign config_out.nrzi_skip = pcr[pcs_pkg::nrzi_bit];
    assign config_out.scrambler_skip = pcr[pcs_pkg::scram_bit];
    assign config_out.descrambler_skip = pcr[pcs_pkg::descram_bit];

    // ---------------------------------------------------------------
    // descrambler loss-of-sync timer
    // ---------------------------------------------------------------
    logic [15:0] timer;
    logic [15:0] limit;

    assign limit = pcr[pcs_pkg::descrambler_timeout_select_bit] ? 16'(pcs_pkg::long_cycles)
                                               : 16'(pcs_pkg::short_cycles);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            timer <= 16'h0000;
        end else if (activity_s || !lock_s) begin
            timer <= 16'h0000;
        end else if (timer < limit) begin
            timer <= timer + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            descrambler_timeout <= 1'b0;
        end else begin
            descrambler_timeout <= (timer >= limit);
        end
    end

    // ---------------------------------------------------------------
    // link qualification
    // ---------------------------------------------------------------
    pcs_pkg::pcs_link_e link_state;
    pcs_pkg::pcs_link_e next_link_state;
    logic level_eff;
    logic lock_eff;

    assign level_eff = level_s || pcr[pcs_pkg::force_sd_bit];
    assign lock_eff = lock_s && !descrambler_timeout;

    always_comb begin
        next_link_state = link_state;
        case (link_state)
            pcs_pkg::link_down: begin
                if (level_eff) begin
                    next_link_state = pcs_pkg::link_wait_lock;
                end
            end
            pcs_pkg::link_wait_lock: begin
                if (!level_eff) begin
                    next_link_state = pcs_pkg::link_down;
                end else if (lock_eff) begin
                    next_link_state = pcs_pkg::link_up;
                end
            end
            pcs_pkg::link_up: begin
                if (!level_eff) begin
                    next_link_state = pcs_pkg::link_down;
                end else if (!pcr[pcs_pkg::sd_alg_bit] && !lock_eff) begin
                    next_link_state = pcs_pkg::link_wait_lock;
                end
            end
            default: begin
                next_link_state = pcs_pkg::link_down;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            link_state <= pcs_pkg::link_down;
        end else begin
            link_state <= next_link_state;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            link_good <= 1'b0;
        end else begin
            link_good <= (next_link_state == pcs_pkg::link_up)
                         || pcr[pcs_pkg::force_ok_bit];
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        if (access && !pwrite) begin
            case (paddr)
                pcs_pkg::rec_addr: prdata = {24'h00_0000, tally};
                pcs_pkg::pcr_addr: prdata = {16'h0000, pcr};
                pcs_pkg::extra_addr: prdata = {29'h0000_0000, descrambler_timeout,
                                               link_state == pcs_pkg::link_up, strap_s};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule

// *** hdl/pcs_error_tally.sv ***
`timescale 1ns/1ps
module pcs_error_tally (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // receive events, already synchronised
    input wire pcs_pkg::pcs_rx_status_s rx,
    // read-clear strobe
    input wire logic clear,
    // count
    output logic [7:0] rx_symbol_error_tally
);

    // ---------------------------------------------------------------
    // per-carrier event capture
    // ---------------------------------------------------------------
    logic counted;
    logic bump;

    assign bump = rx.carrier && rx.symbol_error && !rx.collision && !counted;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            counted <= 1'b0;
        end else if (!rx.carrier) begin
            counted <= 1'b0;
        end else if (bump) begin
            counted <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // saturating counter, event in the clearing cycle counts as one
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_symbol_error_tally <= 8'h00;
        end else if (clear) begin
            rx_symbol_error_tally <= bump ? 8'h01 : 8'h00;
        end else if (bump) begin
            rx_symbol_error_tally <= pcs_pkg::pcs_sat_inc(rx_symbol_error_tally);
        end
    end

endmodule

// *** hdl/pcs_pkg.sv ***
package pcs_pkg;

    // ---------------------------------------------------------------
    // register map (printed offsets are not multiples of four: index)
    // ---------------------------------------------------------------
    localparam logic [7:0] rec_index = 8'h15;
    localparam logic [7:0] pcr_index = 8'h16;
    localparam logic [7:0] extra_index = 8'h17;
    localparam logic [11:0] rec_addr = {2'h0, rec_index, 2'h0};
    localparam logic [11:0] pcr_addr = {2'h0, pcr_index, 2'h0};
    localparam logic [11:0] extra_addr = {2'h0, extra_index, 2'h0};

    // ---------------------------------------------------------------
    // field positions of the configuration register
    // ---------------------------------------------------------------
    localparam int free_clk_bit = 11;
    localparam int true_quiet_bit = 10;
    localparam int force_sd_bit = 9;
    localparam int sd_alg_bit = 8;
    localparam int descrambler_timeout_select_bit = 7;
    localparam int fiber_bit = 6;
    localparam int force_ok_bit = 5;
    localparam int fefi_bit = 3;
    localparam int nrzi_bit = 2;
    localparam int scram_bit = 1;
    localparam int descram_bit = 0;
    localparam logic [15:0] pcr_writable = 16'h0fef;

    // ---------------------------------------------------------------
    // counter and timing
    // ---------------------------------------------------------------
    localparam int count_width = 8;
    localparam logic [7:0] count_max = 8'hff;
    localparam int clock_khz = 10000;
    localparam int timeout_short_us = 722;
    localparam int timeout_long_ms = 2;
    localparam int short_cycles = timeout_short_us * clock_khz / 1000;
    localparam int long_cycles = timeout_long_ms * clock_khz;
    localparam int timer_width = 16;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic carrier;
        logic symbol_error;
        logic collision;
    } pcs_rx_status_s;

    typedef struct packed {
        logic rx_clk_free_run;
        logic true_quiet_enable;
        logic force_signal_detect;
        logic signal_detect_algorithm;
        logic descrambler_timeout_select;
        logic fiber_mode_enable;
        logic force_good_link;
        logic far_end_fault_enable;
        logic nrzi_skip;
        logic scrambler_skip;
        logic descrambler_skip;
    } pcs_config_s;

    typedef enum logic [1:0] {
        link_down,
        link_wait_lock,
        link_up
    } pcs_link_e;

    function automatic logic [7:0] pcs_sat_inc(input logic [7:0] value);
        pcs_sat_inc = (value == count_max) ? value : value + 8'h01;
    endfunction

endpackage

// *** test/pcs_error_counter_config_sva.sv ***
`timescale 1ns/1ps
module pcs_cfg_sva (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // medium and controls
    input wire logic signal_level_valid,
    input wire logic descrambler_locked,
    input wire pcs_pkg::pcs_config_s config_out,
    input wire logic link_good
);
    logic rd_rec;
    logic rd_pcr;
    logic wr_pcr;
    logic [10:0] wr_bits;
    assign rd_rec = psel && penable && !pwrite && paddr == pcs_pkg::rec_addr;
    assign rd_pcr = psel && penable && !pwrite && paddr == pcs_pkg::pcr_addr;
    assign wr_pcr = psel && penable && pwrite && paddr == pcs_pkg::pcr_addr;
    assign wr_bits = {pwdata[11:5], pwdata[3:0]};

    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    rec_upper_a: assert property (rd_rec |-> prdata[31:8] == 24'h0)
        else $error("error count upper bits not zero");
    pcr_zero_a: assert property (rd_pcr |-> prdata[31:12] == 20'h0 && !prdata[4])
        else $error("config unused bits not zero");
    cfg_mirror_a: assert property (rd_pcr |-> prdata[11:0] == {config_out[10:4], 1'b0, config_out[3:0]})
        else $error("config read differs from outputs");
    write_take_a: assert property (wr_pcr |=> config_out == $past(wr_bits))
        else $error("config write not applied");
    force_link_a: assert property (config_out.force_good_link |-> ##[1:3] link_good)
        else $error("forced link not good");
    lock_drop_a: assert property ((!config_out.signal_detect_algorithm && !config_out.force_good_link
        && !descrambler_locked) [*5] |-> !link_good)
        else $error("link kept after lock loss");
    link_hold_a: assert property ((config_out.signal_detect_algorithm && signal_level_valid) [*4]
        ##0 link_good |=> link_good)
        else $error("link dropped while level valid");
    clear_read_a: assert property (rd_rec ##3 rd_rec |-> prdata[7:0] <= 8'h02)
        else $error("count not cleared by read");
endmodule

// *** test/pcs_error_counter_config_tb.sv ***
`timescale 1ns/1ps
module pcs_error_counter_config_tb;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, fiber_strap, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rx_carrier, rx_symbol_error, rx_collision, signal_level_valid, descrambler_locked;
    logic descrambler_activity, link_good, descrambler_timeout;
    pcs_pkg::pcs_config_s config_out;
    int err_count = 0;
    int tests_run = 0;
    int exp_cnt = 0;
    int n;
    logic [15:0] w;

    pcs_error_counter_config dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fiber_strap, .rx_carrier, .rx_symbol_error, .rx_collision,
        .signal_level_valid, .descrambler_locked, .descrambler_activity, .config_out,
        .link_good, .descrambler_timeout);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // --------------------------------------------
    // tasks
    // --------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            err_count++;
            finish_test();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rst_with(input logic s);
        fiber_strap <= s;
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (5) @(posedge clock);
        exp_cnt = 0;
    endtask

    // carrier event with several bad symbols; the model counts it once, or not at all when col is set
    task automatic ev(input logic col);
        @(posedge clock);
        rx_carrier <= 1'b1;
        rx_collision <= col;
        repeat (3) begin
            @(posedge clock);
            rx_symbol_error <= 1'b1;
            @(posedge clock);
            rx_symbol_error <= 1'b0;
        end
        @(posedge clock);
        rx_carrier <= 1'b0;
        rx_collision <= 1'b0;
        repeat (4) @(posedge clock);
        if (!col && exp_cnt < 255) exp_cnt++;
    endtask

    task automatic lk(input logic lv, input logic lock, input logic exp);
        signal_level_valid <= lv;
        descrambler_locked <= lock;
        repeat (8) @(posedge clock);
        chk({31'h0, link_good}, {31'h0, exp});
    endtask

    // --------------------------------------------
    // main sequence
    // --------------------------------------------
    initial begin
        {rst_b, psel, penable, pwrite, fiber_strap, rx_carrier, rx_symbol_error} = '0;
        {rx_collision, signal_level_valid, descrambler_locked, descrambler_activity} = '0;
        paddr = '0;
        pwdata = '0;
        void'($urandom(32'h9ebd));
        rst_with(1'b0);
        apb(1'b0, pcs_pkg::pcr_addr, 0);
        chk(rd, 32'h0100);
        apb(1'b0, pcs_pkg::rec_addr, 0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h060, 0);
        chk({slv, rd[30:0]}, 32'h80000000);
        rst_with(1'b1);
        apb(1'b0, pcs_pkg::pcr_addr, 0);
        chk(rd, 32'h014b);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            w = (i == 0) ? 16'hffff : 16'($urandom);
            apb(1'b1, pcs_pkg::pcr_addr, {16'hffff, w});
            apb(1'b0, pcs_pkg::pcr_addr, 0);
            chk(rd, {16'h0, w & pcs_pkg::pcr_writable});
        end
        $display("test config done");
        apb(1'b1, pcs_pkg::rec_addr, 32'hffff);
        repeat (20) begin
            w = 16'($urandom);
            ev(w[0]);
        end
        apb(1'b0, pcs_pkg::rec_addr, 0);
        chk(rd, 32'(exp_cnt));
        apb(1'b0, pcs_pkg::rec_addr, 0);
        chk(rd, 32'h0);
        exp_cnt = 0;
        repeat (258) ev(1'b0);
        apb(1'b0, pcs_pkg::rec_addr, 0);
        chk(rd, 32'(exp_cnt));
        // error lands on the clearing read edge: the new event must survive
        rx_carrier <= 1'b1;
        repeat (4) @(posedge clock);
        rx_symbol_error <= 1'b1;
        apb(1'b0, pcs_pkg::rec_addr, 0);
        chk(rd, 32'h0);
        rx_symbol_error <= 1'b0;
        rx_carrier <= 1'b0;
        repeat (4) @(posedge clock);
        apb(1'b0, pcs_pkg::rec_addr, 0);
        chk(rd, 32'h1);
        $display("test counter done");
        apb(1'b1, pcs_pkg::pcr_addr, 32'h0100);
        lk(1'b1, 1'b1, 1'b1);
        lk(1'b1, 1'b0, 1'b1);
        lk(1'b0, 1'b0, 1'b0);
        apb(1'b1, pcs_pkg::pcr_addr, 32'h0);
        lk(1'b1, 1'b1, 1'b1);
        lk(1'b1, 1'b0, 1'b0);
        apb(1'b1, pcs_pkg::pcr_addr, 32'h0020);
        lk(1'b0, 1'b0, 1'b1);
        apb(1'b1, pcs_pkg::pcr_addr, 32'h0200);
        lk(1'b0, 1'b1, 1'b1);
        // status word: strap high, link up, no timeout
        apb(1'b0, pcs_pkg::extra_addr, 0);
        chk(rd, 32'h3);
        $display("test link done");
        for (int s = 0; s < 2; s++) begin
            n = s ? pcs_pkg::long_cycles : pcs_pkg::short_cycles;
            apb(1'b1, pcs_pkg::pcr_addr, s ? 32'h0080 : 32'h0);
            descrambler_activity <= 1'b1;
            repeat (4) @(posedge clock);
            descrambler_activity <= 1'b0;
            repeat (n - 20) @(posedge clock);
            chk({31'h0, descrambler_timeout}, 32'h0);
            repeat (60) @(posedge clock);
            chk({31'h0, descrambler_timeout}, 32'h1);
        end
        $display("test timeout done");
        finish_test();
    end
endmodule

bind pcs_error_counter_config pcs_cfg_sva sva_i (.clock, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .signal_level_valid, .descrambler_locked, .config_out, .link_good);
